// file: src/irq_arb_consts.svh
// Register offsets, field positions and reset values of the interrupt arbiter
`ifndef IRQ_ARB_CONSTS_SVH
`define IRQ_ARB_CONSTS_SVH

// ==========================================================
// Register offsets
`define OFS_ENABLE_MAIN    8'ha8
`define OFS_LEVEL_LOW      8'ha9
`define OFS_LEVEL_HIGH     8'hb9
`define OFS_ENABLE_SECOND  8'hb8
`define OFS_ENABLE_THIRD   8'h9a
`define OFS_ENABLE_FOURTH  8'hd1
`define OFS_TIMER2_FLAGS   8'hc0
`define OFS_ANALOG_FLAGS   8'hbf
`define OFS_PENDING_LO     8'he0
`define OFS_PENDING_HI     8'he1
`define OFS_SERVICE_STATE  8'he2

// ==========================================================
// Writable bit masks and reset values
`define MASK_ENABLE_MAIN   8'hbf
`define MASK_LEVEL         8'h3f
`define MASK_ENABLE_SECOND 8'hbf
`define MASK_ENABLE_THIRD  8'h3e
`define MASK_ENABLE_FOURTH 8'hc0
`define MASK_TIMER2_FLAGS  8'hfc
`define MASK_ANALOG_FLAGS  8'h1f
`define RESET_BYTE         8'h00
`define GLOBAL_ENABLE_BIT  7

// ==========================================================
// Source count, group count and level count
`define NUM_SOURCES        19
`define NUM_GROUPS         6
`define NUM_LEVELS         4
`define NO_SOURCE          5'h1f

`endif

// file: src/irq_arb_pkg.sv
// Types shared by the interrupt arbiter files
package irq_arb_pkg;

  // ==========================================================
  // Register port carrier
  typedef struct packed
  {
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } reg_req_t;

  // Vector request towards the core
  typedef struct packed
  {
    logic       valid;  // Request held for the core
    logic [4:0] src;    // Source index in natural order
    logic [1:0] level;  // Level of that source
  } vec_req_t;

  // Offer tracker states
  typedef enum logic [1:0] {ST_IDLE, ST_OFFER} offer_state_t;

endpackage

// file: src/irq_pick.sv
// Three-step priority pick over all enabled pending sources
`timescale 1ns/1ps
`include "irq_arb_consts.svh"

module irq_pick
(
  input  wire logic [18:0] pend_i,   // Pending and enabled, natural order
  input  wire logic [5:0]  lvl_lo_i, // Level low bits per group
  input  wire logic [5:0]  lvl_hi_i, // Level high bits per group
  output logic             hit_o,    // Some source is picked
  output logic [4:0]       src_o,    // Picked source index
  output logic [1:0]       lvl_o     // Picked source level
);

  // ==========================================================
  // Group of each source
  function automatic logic [2:0] group_of(input logic [4:0] s);
    group_of = (s == 5'h12) ? 3'h5 : 3'(s / 5'h03); // RULE_08
  endfunction

  // Scan by level, high first; lowest index wins inside a level
  always_comb
  begin
    logic [2:0] g;
    g     = 3'h0;
    hit_o = 1'b0;
    src_o = `NO_SOURCE;
    lvl_o = 2'h0;
    for (int l = `NUM_LEVELS - 1; l >= 0; l--)
    begin
      for (int s = 0; s < `NUM_SOURCES; s++)
      begin
        g = group_of(5'(s));
        // Group order equals source order, so one scan covers steps two and three
        if (!hit_o && pend_i[s] && {lvl_hi_i[g], lvl_lo_i[g]} == 2'(l)) // RULE_09 RULE_05
        begin
          hit_o = 1'b1;
          src_o = 5'(s);
          lvl_o = 2'(l);
        end
      end
    end
  end

endmodule

// file: src/irq_stack.sv
// Per-level in-service stack, one bit for each level
`timescale 1ns/1ps
`include "irq_arb_consts.svh"

module irq_stack
(
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_i,   // Asynchronous reset
  input  wire logic       push_i,  // A vector was taken
  input  wire logic [1:0] lvl_i,   // Its level
  input  wire logic       pop_i,   // Return from interrupt
  output logic            busy_o,  // Any routine in service
  output logic [1:0]      top_o,   // Level now running
  output logic [3:0]      bits_o   // Raw in-service bits
);

  logic [3:0] insvc_r; // One bit per level in service

  // Levels only nest upward, so the top is the highest set bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      insvc_r <= 4'h0;
    else
    begin
      logic [3:0] v;
      v = insvc_r;
      if (pop_i && busy_o)
        v[top_o] = 1'b0;               // RULE_20 RULE_21
      if (push_i)
        v[lvl_i] = 1'b1;               // RULE_21
      insvc_r <= v;
    end
  end

  // Highest set bit
  always_comb
  begin
    top_o = 2'h0;
    for (int i = 0; i < `NUM_LEVELS; i++)
      if (insvc_r[i])
        top_o = 2'(i);
  end

  assign busy_o = |insvc_r;
  assign bits_o = insvc_r;

endmodule

// file: src/irq_arbiter.sv
// Grouped four-level interrupt arbiter with enables, flags and nesting
//
// What this block does
// RULE_01: Equal level together: natural order first
// RULE_02: Equal or lower level never preempts
// RULE_03: Six groups, each one of four levels
// RULE_04: Level code is high bit, low bit
// RULE_05: Equal levels resolve by natural order
// RULE_06: Strictly higher level preempts, nesting service
// RULE_07: Lower level stays pending, never lost
// RULE_08: Fixed membership of sources in groups
// RULE_09: Pick level, then group, then source
// RULE_10: Level registers: bits 5..0, rest zero
// RULE_11: Global enable gates every request
// RULE_12: First enable register bit layout
// RULE_13: Second enable register bit layout
// RULE_14: Third and fourth register layouts
// RULE_15: First flag register bit layout
// RULE_16: Second flag register bit layout
// RULE_17: Flags set on event regardless of enable
// RULE_18: Fixed natural order of nineteen sources
// RULE_19: Some flags hardware cleared, others software
// RULE_20: Return from interrupt ends a routine
// RULE_21: Track nested levels on a stack
`timescale 1ns/1ps
`include "irq_arb_consts.svh"

module irq_arbiter
(
  input  wire logic        CLK_I,        // System clock, 10 MHz
  input  wire logic        RST_I,        // Asynchronous reset, active high
  input  wire logic [7:0]  ADDR_I,       // Register offset
  input  wire logic [7:0]  WDATA_I,      // Write data
  input  wire logic        WR_I,         // Write strobe
  input  wire logic        RD_I,         // Read strobe
  output logic      [7:0]  RDATA_O,      // Read data, cycle after strobe
  input  wire logic [18:0] EVENT_I,      // Source events, natural order
  input  wire logic [18:0] EXT_FLAG_I,   // Flags held inside peripherals
  input  wire logic        T2RL_EVENT_I, // Timer2 reload event
  input  wire logic        ACK_I,        // Core takes the offered vector
  input  wire logic        RETURN_FROM_INTERRUPT_I,       // Core returns from interrupt
  output logic             IRQ_O,        // Vector request to the core
  output logic      [4:0]  VEC_SRC_O,    // Offered source index
  output logic      [1:0]  VEC_LVL_O,    // Offered source level
  output logic      [18:0] HW_CLR_O      // Clear pulse to peripheral flag
);

  // ==========================================================
  // Source indices in natural order
  localparam int S_EXT0 = 0; // RULE_18
  localparam int S_ITEMA = 1;
  localparam int S_I2C = 2;
  localparam int S_TMR0 = 3;
  localparam int S_PWM2 = 4;
  localparam int S_SPI = 5;

  localparam int S_EXT1 = 6;
  localparam int S_PWM3 = 7;
  localparam int S_CMPR0 = 8;
  localparam int S_TMR1 = 9;
  localparam int S_ADC = 10;
  localparam int S_CMPR1 = 11;

  localparam int S_UART = 12;
  localparam int S_CMP0 = 13;
  localparam int S_CMPR2 = 14;
  localparam int S_TMR2 = 15;
  localparam int S_CMP1 = 16;
  localparam int S_EXT2 = 17;
  localparam int S_CMPR3 = 18;

  // Sources whose flags hardware clears on service
  localparam logic [18:0] HW_CLEARED = 19'h64b49; // RULE_19

  // Flags that live in this block's registers
  localparam logic [18:0] LOCAL_FLAGS = 19'h7fd92;

  // ==========================================================
  // Registers
  logic [7:0]  en_main_r;    // Global and first enables
  logic [7:0]  lvl_lo_r;     // Level low bits
  logic [7:0]  lvl_hi_r;     // Level high bits
  logic [7:0]  en_second_r;  // Compare, spi, i2c enables
  logic [7:0]  en_third_r;   // Analog and pwm enables
  logic [7:0]  en_fourth_r;  // item_a and ext2 enables
  logic [18:0] flag_r;       // Locally held request flags
  logic        t2rl_flag_r;  // Timer2 reload flag

  logic [18:0] enable;       // Per-source enable, natural order
  logic [18:0] flags;        // All flags, natural order
  logic [18:0] pend;         // Pending and enabled
  logic [18:0] elig;         // Pending and not already offered

  logic        wr_ok;        // Write strobe seen
  irq_arb_pkg::vec_req_t vec_r; // Offered vector
  irq_arb_pkg::reg_req_t req;
  irq_arb_pkg::offer_state_t st_r;

  logic        pick_hit;     // Arbiter found a source
  logic [4:0]  pick_src;     // Its index
  logic [1:0]  pick_lvl;     // Its level

  logic        busy;         // Routine in service
  logic [1:0]  top_lvl;      // Level running now
  logic [3:0]  insvc;        // In-service bits
  logic        take;         // Core takes vector this cycle

  // Register port as one struct

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign wr_ok = req.wr;

  // ==========================================================
  // Enable map in natural order
  always_comb
  begin
    enable = '0;
    enable[S_EXT0]  = en_main_r[0];   // RULE_12
    enable[S_TMR0]  = en_main_r[1];
    enable[S_EXT1]  = en_main_r[2];
    enable[S_TMR1]  = en_main_r[3];
    enable[S_UART]  = en_main_r[4];
    enable[S_TMR2]  = en_main_r[5];
    enable[S_I2C]   = en_second_r[0]; // RULE_13
    enable[S_SPI]   = en_second_r[1];
    enable[S_CMPR0] = en_second_r[2];
    enable[S_CMPR1] = en_second_r[3];
    enable[S_CMPR2] = en_second_r[4];
    enable[S_CMPR3] = en_second_r[5];
    enable[S_PWM2]  = en_third_r[1];  // RULE_14
    enable[S_PWM3]  = en_third_r[2];
    enable[S_ADC]   = en_third_r[3];
    enable[S_CMP0]  = en_third_r[4];
    enable[S_CMP1]  = en_third_r[5];
    enable[S_EXT2]  = en_fourth_r[6];
    enable[S_ITEMA] = en_fourth_r[7];
  end

  // Timer2 raises through its own flag or the reload flag
  always_comb
  begin
    flags = (flag_r & LOCAL_FLAGS) | (EXT_FLAG_I & ~LOCAL_FLAGS);
    flags[S_TMR2] = flag_r[S_TMR2] | (t2rl_flag_r & en_second_r[7]);
  end

  // Global enable gates everything
  // Disabled flags stay set; only the request is masked
  assign pend = en_main_r[`GLOBAL_ENABLE_BIT] ? (flags & enable) : '0; // RULE_11 RULE_17

  // The offered source is masked out while the core has not taken it
  // Without this the same source could be offered twice
  always_comb
  begin
    elig = pend;
    if (vec_r.valid)
      elig[vec_r.src] = 1'b0;
  end

  // ==========================================================
  // Arbitration and nesting
  irq_pick u_pick
  (
    .pend_i   (elig),
    .lvl_lo_i (lvl_lo_r[5:0]),
    .lvl_hi_i (lvl_hi_r[5:0]),
    .hit_o    (pick_hit),
    .src_o    (pick_src),
    .lvl_o    (pick_lvl)
  );

  // A stray acknowledge without an offer is ignored
  assign take = vec_r.valid && ACK_I;

  // Pop before push when both fall together
  irq_stack u_stack
  (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .push_i (take),
    .lvl_i  (vec_r.level),
    .pop_i  (RETURN_FROM_INTERRUPT_I),
    .busy_o (busy),
    .top_o  (top_lvl),
    .bits_o (insvc)
  );

  // ==========================================================
  // Offer state: hold one vector until taken or withdrawn
  // Later, higher requests wait for the next decision
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st_r  <= irq_arb_pkg::ST_IDLE;
      vec_r <= '{valid: 1'b0, src: `NO_SOURCE, level: 2'h0};
    end
    else
    begin
      unique case (st_r)
        irq_arb_pkg::ST_IDLE:
        begin
          // Only a strictly higher level breaks in; others wait
          if (pick_hit && !take && (!busy || pick_lvl > top_lvl)) // RULE_02 RULE_06 RULE_07
          begin
            st_r  <= irq_arb_pkg::ST_OFFER;
            vec_r <= '{valid: 1'b1, src: pick_src, level: pick_lvl}; // RULE_01
          end
        end
        irq_arb_pkg::ST_OFFER:
        begin
          // Withdraw if disabled before the core took it
          if (take || !pend[vec_r.src])
          begin
            st_r  <= irq_arb_pkg::ST_IDLE;
            vec_r <= '{valid: 1'b0, src: `NO_SOURCE, level: 2'h0};
          end
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign IRQ_O     = vec_r.valid;
  assign VEC_SRC_O = vec_r.src;
  assign VEC_LVL_O = vec_r.level;

  // ==========================================================
  // Hardware clear pulses for peripheral-held flags
  // Local flags clear in place, with no pulse
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      HW_CLR_O <= '0;
    else
    begin
      HW_CLR_O <= '0;
      if (take && HW_CLEARED[vec_r.src] && !LOCAL_FLAGS[vec_r.src])
        HW_CLR_O[vec_r.src] <= 1'b1; // RULE_19
    end
  end

  // ==========================================================
  // Control registers; reserved bits never store
  // Unmapped offsets change nothing
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      en_main_r   <= `RESET_BYTE;
      lvl_lo_r    <= `RESET_BYTE;
      lvl_hi_r    <= `RESET_BYTE;
      en_second_r <= `RESET_BYTE;
      en_third_r  <= `RESET_BYTE;
      en_fourth_r <= `RESET_BYTE;
    end
    else if (wr_ok)
    begin
      unique case (req.addr)
        `OFS_ENABLE_MAIN:   en_main_r   <= req.wdata & `MASK_ENABLE_MAIN;   // RULE_11 RULE_12
        `OFS_LEVEL_LOW:     lvl_lo_r    <= req.wdata & `MASK_LEVEL;         // RULE_10 RULE_04
        `OFS_LEVEL_HIGH:    lvl_hi_r    <= req.wdata & `MASK_LEVEL;         // RULE_10 RULE_03
        `OFS_ENABLE_SECOND: en_second_r <= req.wdata & `MASK_ENABLE_SECOND; // RULE_13
        `OFS_ENABLE_THIRD:  en_third_r  <= req.wdata & `MASK_ENABLE_THIRD;  // RULE_14
        `OFS_ENABLE_FOURTH: en_fourth_r <= req.wdata & `MASK_ENABLE_FOURTH;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Local flags: event set beats any clear in the same cycle
  // Clear, then software write, then event set
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      flag_r      <= '0;
      t2rl_flag_r <= 1'b0;
    end
    else
    begin
      logic [18:0] f;
      logic        rl;
      f  = flag_r;
      rl = t2rl_flag_r;
      if (take && HW_CLEARED[vec_r.src])
        f[vec_r.src] = 1'b0;                        // RULE_19
      if (wr_ok && req.addr == `OFS_TIMER2_FLAGS)   // RULE_15
      begin
        rl         = req.wdata[7];
        f[S_TMR2]  = req.wdata[6];
        f[S_CMPR3] = req.wdata[5];
        f[S_CMPR2] = req.wdata[4];
        f[S_CMPR1] = req.wdata[3];
        f[S_CMPR0] = req.wdata[2];
      end
      if (wr_ok && req.addr == `OFS_ANALOG_FLAGS)   // RULE_16
      begin
        f[S_CMP1] = req.wdata[4];
        f[S_CMP0] = req.wdata[3];
        f[S_ADC]  = req.wdata[2];
        f[S_PWM3] = req.wdata[1];
        f[S_PWM2] = req.wdata[0];
      end
      if (wr_ok && req.addr == `OFS_ENABLE_FOURTH)
        f[S_ITEMA] = req.wdata[3];                  // RULE_14
      f  = f | (EVENT_I & LOCAL_FLAGS);             // RULE_17
      rl = rl | T2RL_EVENT_I;
      flag_r      <= f;
      t2rl_flag_r <= rl;
    end
  end

  // ==========================================================
  // Read data one cycle after the strobe, zero otherwise
  // Zero between answers keeps a shared bus quiet
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      RDATA_O <= `RESET_BYTE;
    else if (!req.rd)
      RDATA_O <= `RESET_BYTE;
    else
    begin
      unique case (req.addr)
        `OFS_ENABLE_MAIN:   RDATA_O <= en_main_r;
        `OFS_LEVEL_LOW:     RDATA_O <= lvl_lo_r;   // RULE_10
        `OFS_LEVEL_HIGH:    RDATA_O <= lvl_hi_r;
        `OFS_ENABLE_SECOND: RDATA_O <= en_second_r;
        `OFS_ENABLE_THIRD:  RDATA_O <= en_third_r;
        `OFS_ENABLE_FOURTH: RDATA_O <= {en_fourth_r[7:6], 2'h0, flag_r[S_ITEMA],
                                        flags[S_EXT2], 2'h0};
        `OFS_TIMER2_FLAGS:  RDATA_O <= {t2rl_flag_r, flag_r[S_TMR2], flag_r[S_CMPR3],
                                        flag_r[S_CMPR2], flag_r[S_CMPR1],
                                        flag_r[S_CMPR0], 2'h0};
        `OFS_ANALOG_FLAGS:  RDATA_O <= {3'h0, flag_r[S_CMP1], flag_r[S_CMP0],
                                        flag_r[S_ADC], flag_r[S_PWM3], flag_r[S_PWM2]};
        `OFS_PENDING_LO:    RDATA_O <= pend[7:0];
        `OFS_PENDING_HI:    RDATA_O <= pend[15:8];
        `OFS_SERVICE_STATE: RDATA_O <= {insvc, 1'b0, pend[18:16]};
        default:            RDATA_O <= `RESET_BYTE;
      endcase
    end
  end

endmodule

// file: dv/irq_arbiter_sva.sv
// Port-level checker of the interrupt arbiter
`timescale 1ns/1ps
module irq_arbiter_chk
(
  input wire logic        CLK_I,     // System clock
  input wire logic        RST_I,     // Asynchronous reset
  input wire logic [7:0]  ADDR_I,    // Register offset
  input wire logic [7:0]  WDATA_I,   // Write data
  input wire logic        WR_I,      // Write strobe
  input wire logic        RD_I,      // Read strobe
  input wire logic [7:0]  RDATA_O,   // Read data
  input wire logic        ACK_I,     // Core takes vector
  input wire logic        RETURN_FROM_INTERRUPT_I,    // Core returns
  input wire logic        IRQ_O,     // Vector request
  input wire logic [4:0]  VEC_SRC_O, // Offered source
  input wire logic [1:0]  VEC_LVL_O, // Offered level
  input wire logic [18:0] HW_CLR_O   // Peripheral flag clears
);
  // ==========================================================
  // Shadow state
  logic       glob_r; // Global enable as written
  logic [5:0] lo_r;   // Level low bits
  logic [5:0] hi_r;   // Level high bits
  logic [3:0] insv_r; // Levels in service
  logic [1:0] top;    // Level now running
  logic [4:0] grp;    // Group of the offered source
  assign top = insv_r[3] ? 2'h3 : insv_r[2] ? 2'h2 : {1'b0, insv_r[1]};
  // Groups hold three sources each, the last one four
  assign grp = (VEC_SRC_O < 5'h0f) ? VEC_SRC_O / 5'h03 : 5'h05;
  // Register shadows, fed from the write port only
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I)
    begin
      glob_r <= 1'b0;
      lo_r   <= 6'h00;
      hi_r   <= 6'h00;
    end
    else if (WR_I)
    begin
      if (ADDR_I == 8'ha8) glob_r <= WDATA_I[7];
      if (ADDR_I == 8'ha9) lo_r <= WDATA_I[5:0];
      if (ADDR_I == 8'hb9) hi_r <= WDATA_I[5:0];
    end
  // Push on take, pop the top level on return
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I)
      insv_r <= 4'h0;
    else
      insv_r <= (insv_r & ~({3'h0, RETURN_FROM_INTERRUPT_I} << top)) | ({3'h0, IRQ_O & ACK_I} << VEC_LVL_O);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_global_gate: assert property (!glob_r |=> !IRQ_O)
    else $error("request raised while globally disabled");
  a_level_reserved: assert property ($past(RD_I) && ($past(ADDR_I) == 8'ha9 ||
    $past(ADDR_I) == 8'hb9) |-> RDATA_O[7:6] == 2'h0) else $error("level spare bits set");
  a_level_readback: assert property ($past(RD_I) && $past(ADDR_I) == 8'ha9
    |-> RDATA_O[5:0] == $past(lo_r)) else $error("level low bits read wrong");
  a_main_layout: assert property ($past(RD_I) && $past(ADDR_I) == 8'ha8
    |-> !RDATA_O[6] && RDATA_O[7] == $past(glob_r)) else $error("main enable read wrong");
  a_ack_drop: assert property (IRQ_O && ACK_I |=> !IRQ_O)
    else $error("request held after take");
  a_level_map: assert property (IRQ_O && $stable(lo_r) && $stable(hi_r)
    |-> VEC_LVL_O == {hi_r[grp], lo_r[grp]}) else $error("offered level wrong");
  a_no_preempt: assert property (IRQ_O && insv_r != 4'h0
    |-> VEC_LVL_O > top) else $error("offer not above running level");
  a_hw_clr_only: assert property ((HW_CLR_O & 19'h7fdb6) == 19'h00000)
    else $error("clear pulse to a software-cleared flag");
endmodule

bind irq_arbiter irq_arbiter_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ACK_I(ACK_I),
  .RETURN_FROM_INTERRUPT_I(RETURN_FROM_INTERRUPT_I), .IRQ_O(IRQ_O), .VEC_SRC_O(VEC_SRC_O), .VEC_LVL_O(VEC_LVL_O),
  .HW_CLR_O(HW_CLR_O));

// file: dv/irq_core_model.sv
// Behavioural CPU core that takes vectors and returns from routines
`timescale 1ns/1ps
module irq_core_model
(
  input  wire logic clk_i,     // System clock
  input  wire logic rst_i,     // Asynchronous reset
  input  wire logic irq_i,     // Vector request
  input  wire logic slow_i,    // Take vectors late
  input  wire logic ret_cmd_i, // Routine body finished
  output logic      ack_o,     // Vector taken
  output logic      return_from_interrupt_o     // Return from interrupt
);
  logic [1:0] wait_r;  // Cycles spent looking at an offer
  logic [2:0] depth_r; // Routines still open
  // Take at once, or after three cycles when slow
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      wait_r <= 2'h0;
      ack_o  <= 1'b0;
    end
    else
    begin
      ack_o  <= irq_i && !ack_o && (!slow_i || wait_r == 2'h3);
      wait_r <= (irq_i && !ack_o && wait_r != 2'h3) ? wait_r + 2'h1 : 2'h0;
    end
  // Return only from a routine really entered, so no stray pops
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      depth_r <= 3'h0;
      return_from_interrupt_o  <= 1'b0;
    end
    else
    begin
      return_from_interrupt_o  <= ret_cmd_i && depth_r != 3'h0;
      depth_r <= depth_r + {2'h0, irq_i && ack_o} - {2'h0, ret_cmd_i && depth_r != 3'h0};
    end
endmodule

// file: dv/tb_irq_arbiter.sv
// Self-checking testbench of the interrupt arbiter
`timescale 1ns/1ps
module tb_irq_arbiter;
  // ==========================================================
  // Signals
  logic        clk, rst, wr, rd, rd_d, slow, ret_cmd, ack, return_from_interrupt, irq;  // Controls
  logic [7:0]  addr, wdata, rdata; // Register port
  logic [18:0] ev, xf, hw_clr;     // Events, held flags, clears
  logic [4:0]  vsrc;               // Offered source
  logic [1:0]  vlvl;               // Offered level
  logic [7:0]  rd_q[$];            // Expected read data
  logic [6:0]  vec_q[$];           // Expected {level, source}
  int          mismatches, n_compared, seed, i, j;
  logic [5:0]  lo, hi;             // Random level bits
  logic [15:0] keep;               // Flags left for the loser
  logic [4:0]  src_tab[10] = '{5'h04, 5'h07, 5'h08, 5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h0f,
                                5'h10, 5'h12};
  // Flag of each source as {timer2 flags, analog flags}
  logic [15:0] flg_tab[10] = '{16'h0001, 16'h0002, 16'h0400, 16'h0004, 16'h0800,
                                16'h0008, 16'h1000, 16'h4000, 16'h0010, 16'h2000};
  logic [7:0]  ofs_tab[8] = '{8'ha8, 8'ha9, 8'hb9, 8'hb8, 8'h9a, 8'hd1, 8'hc0, 8'hbf};

  irq_arbiter dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .EVENT_I(ev), .EXT_FLAG_I(xf), .T2RL_EVENT_I(1'b0),
    .ACK_I(ack), .RETURN_FROM_INTERRUPT_I(return_from_interrupt), .IRQ_O(irq), .VEC_SRC_O(vsrc), .VEC_LVL_O(vlvl),
    .HW_CLR_O(hw_clr));
  irq_core_model core (.clk_i(clk), .rst_i(rst), .irq_i(irq), .slow_i(slow),
    .ret_cmd_i(ret_cmd), .ack_o(ack), .return_from_interrupt_o(return_from_interrupt));

  // ==========================================================
  // Clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Level of a source from its group and the random level bits
  function automatic logic [1:0] lvl_of(input logic [4:0] s);
    int g;
    g = (s < 5'h0f) ? s / 3 : 5;
    return {hi[g], lo[g]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus cycles, one strobe cycle each
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask
  task automatic fire(input logic [18:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 19'h00000;
  endtask
  // Bounded wait for the core to take a vector
  task automatic wait_ack;
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clk);
      if (irq === 1'b1 && ack === 1'b1)
        break;
    end
  endtask
  task automatic ret;
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    if (vec_q.size() + rd_q.size() != 0)
    begin
      mismatches++;
      $display("Error at %0t: expected results never seen", $time);
    end
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Monitor: oldest note against each read answer and each taken vector
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d === 1'b1)
      check(rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx);
    if (irq === 1'b1 && ack === 1'b1)
      check({1'b0, vlvl, vsrc}, (vec_q.size() > 0) ? {1'b0, vec_q.pop_front()} : 8'hff);
  end
  // Watchdog, well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: timeout", $time);
    tally_and_finish;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {rst, wr, rd, slow, ret_cmd, addr, wdata, ev, xf} = '0;
    rst = 1'b1;
    seed = 32'h7a64;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset values, spare bits, unmapped offset
    foreach (ofs_tab[k]) rd_chk(ofs_tab[k], 8'h00);
    rd_chk(8'h55, 8'h00);
    wr_reg(8'ha9, 8'hff);
    wr_reg(8'hb9, 8'hff);
    wr_reg(8'ha8, 8'h7f);
    wr_reg(8'h9a, 8'hff);
    rd_chk(8'ha9, 8'h3f);
    rd_chk(8'hb9, 8'h3f);
    rd_chk(8'ha8, 8'h3f);
    rd_chk(8'h9a, 8'h3e);
    wr_reg(8'ha9, 8'h00);
    wr_reg(8'hb9, 8'h00);
    wr_reg(8'ha8, 8'h20);
    wr_reg(8'hb8, 8'h3c);
    // Flag set while globally off; offered only once enabled
    fire(19'h02000);
    repeat (6) @(posedge clk);
    rd_chk(8'hbf, 8'h08);
    vec_q.push_back({2'h0, 5'h0d});
    wr_reg(8'ha8, 8'ha0);
    wait_ack;
    wr_reg(8'hbf, 8'h00);
    ret;
    // Same level together: natural order, second waits for the return
    vec_q.push_back({2'h0, 5'h04});
    vec_q.push_back({2'h0, 5'h0d});
    fire(19'h02010);
    wait_ack;
    wr_reg(8'hbf, 8'h08);
    ret;
    wait_ack;
    wr_reg(8'hbf, 8'h00);
    ret;
    // Nesting: level 3 breaks in, lower request held over two returns
    wr_reg(8'ha9, 8'h10);
    wr_reg(8'hb9, 8'h10);
    vec_q.push_back({2'h0, 5'h04});
    fire(19'h00010);
    wait_ack;
    vec_q.push_back({2'h3, 5'h0d});
    fire(19'h02000);
    wait_ack;
    fire(19'h00080);
    wr_reg(8'hbf, 8'h02);
    ret;
    vec_q.push_back({2'h0, 5'h07});
    ret;
    wait_ack;
    wr_reg(8'hbf, 8'h00);
    ret;
    // Peripheral-held ext0: pending view, in service, clear pulse
    wr_reg(8'ha8, 8'ha1);
    vec_q.push_back({2'h0, 5'h00});
    xf <= 19'h00001;
    wait_ack;
    @(posedge clk);
    check(hw_clr[7:0], 8'h01);
    rd_chk(8'he0, 8'h01);
    rd_chk(8'he2, 8'h10);
    xf <= 19'h00000;
    ret;
    // Random levels, two sources at once, random core speed
    for (int n = 0; n < 12; n++)
    begin
      lo = 6'($random(seed));
      hi = 6'($random(seed));
      i = $unsigned($random(seed)) % 10;
      j = (i + 1 + $unsigned($random(seed)) % 9) % 10;
      slow <= 1'($random(seed));
      wr_reg(8'ha9, {2'h0, lo});
      wr_reg(8'hb9, {2'h0, hi});
      if (i > j)
        {i, j} = {j, i};
      if (lvl_of(src_tab[j]) > lvl_of(src_tab[i]))
        {i, j} = {j, i};
      vec_q.push_back({lvl_of(src_tab[i]), src_tab[i]});
      vec_q.push_back({lvl_of(src_tab[j]), src_tab[j]});
      keep = flg_tab[j];
      fire((19'h00001 << src_tab[i]) | (19'h00001 << src_tab[j]));
      wait_ack;
      wr_reg(8'hbf, keep[7:0]);
      wr_reg(8'hc0, keep[15:8]);
      ret;
      wait_ack;
      wr_reg(8'hbf, 8'h00);
      wr_reg(8'hc0, 8'h00);
      ret;
    end
    tally_and_finish;
  end
endmodule
